// file: sim/isf_frame_monitor.sv
// Purpose: port checks of the input state frame block
// Assumes: one clock domain, async low reset
// Notes: pin based counts allow for synchroniser delay
module isf_frame_monitor #(
  parameter int UV_FILTER_CYC = isf_pkg::UV_FILTER_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic i_cs_n,
  input wire logic i_por_n,
  input wire logic i_uv_below_on,
  input wire logic i_ot_above_on,
  input wire logic i_ot_below_off,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_in_ready,
  input wire logic o_undervoltage_alarm_n,
  input wire logic o_overtemp_alarm_n,
  input wire logic [7:0] o_channel_state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] uv_run_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // run of comparator highs, saturates so it never wraps
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) uv_run_r <= 16'h0000;
    else if (!i_uv_below_on) uv_run_r <= 16'h0000;
    else if (uv_run_r < UV_FILTER_CYC + 6) uv_run_r <= uv_run_r + 16'h0001;
  end
  idle_hiz_a: assert property (i_cs_n [*6] |-> !o_miso_oe)
    else $error("output driven while deselected");
  select_drive_a: assert property (
    $fell(i_cs_n) |-> ##[1:6] o_miso_oe)
    else $error("no drive after select");
  state_hold_a: assert property (
    !i_cs_n [*6] |-> $stable(o_channel_state))
    else $error("state moved in frame");
  power_low_a: assert property (
    (!i_por_n && o_miso_oe) [*5] |-> !o_miso)
    else $error("output high on power loss");
  uv_set_a: assert property (
    uv_run_r == UV_FILTER_CYC + 6 |-> !o_undervoltage_alarm_n)
    else $error("undervoltage not flagged");
  uv_filter_a: assert property (
    $fell(o_undervoltage_alarm_n) |-> uv_run_r >= UV_FILTER_CYC - 2)
    else $error("short dropout flagged");
  ot_set_a: assert property (
    i_ot_above_on [*5] |-> !o_overtemp_alarm_n)
    else $error("overtemp not flagged");
  ot_clear_a: assert property (
    (i_ot_below_off && !i_ot_above_on) [*5] |-> o_overtemp_alarm_n)
    else $error("overtemp not released");
  cover property (o_miso_oe && !i_por_n);
  cover property (!o_in_ready);
  cover property ($rose(o_undervoltage_alarm_n));
endmodule

// file: sim/isf_spi_master.sv
// Purpose: behavioural mode 0 link master
// Assumes: moves on falling i_clk, sck period 8 clocks
// Notes: miso sampled late in the high phase, the slave needs 3 clocks
module isf_spi_master (
  // clock
  input wire logic i_clk,
  // link
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [23:0] rx);
    logic b;
    rx = 24'h000000;
    @(negedge i_clk) o_cs_n = 1'b0;
    repeat (10) @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_mosi = (i < 8) ? tx[7-i] : 1'b0;
      @(negedge i_clk) o_sck = 1'b1;
      repeat (3) @(negedge i_clk);
      // a released line reads as the inverse of its last value
      b = i_miso_oe ? i_miso : ~last;
      last = b;
      rx = {rx[22:0], b};
      @(negedge i_clk) o_sck = 1'b0;
      repeat (3) @(negedge i_clk);
    end
    o_cs_n = 1'b1;
    // gap between frames sets the scan rate of the master
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// file: sim/test_input_state_spi_frame.sv
// Purpose: self checking bench of the input state frame block
// Assumes: 50 MHz clock, filter shortened to 20 cycles
// Notes: frames carry a mosi byte after the frame to see the chain
module test_input_state_spi_frame;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_in_valid = 1'b0, i_por_n = 1'b1;
  logic i_frame_length_select = 1'b0, i_uv_below_on = 1'b0;
  logic i_uv_above_off = 1'b1, i_ot_above_on = 1'b0, i_ot_below_off = 1'b1;
  logic [7:0] i_in_data = 8'h00, o_channel_state;
  logic i_sck, i_cs_n, i_mosi, o_miso, o_miso_oe, o_in_ready;
  logic o_undervoltage_alarm_n, o_overtemp_alarm_n;
  logic [31:0] seed = 32'h4AA0;
  int fails = 0, check_count = 0;
  always #10 i_clk = ~i_clk;
  isf_input_state_spi_frame #(.UV_FILTER_CYC(20)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_in_valid(i_in_valid), .i_in_data(i_in_data),
    .o_in_ready(o_in_ready),
    .i_sck(i_sck), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .i_frame_length_select(i_frame_length_select), .i_por_n(i_por_n),
    .i_uv_below_on(i_uv_below_on), .i_uv_above_off(i_uv_above_off),
    .i_ot_above_on(i_ot_above_on), .i_ot_below_off(i_ot_below_off),
    .o_undervoltage_alarm_n(o_undervoltage_alarm_n),
    .o_overtemp_alarm_n(o_overtemp_alarm_n),
    .o_channel_state(o_channel_state));
  isf_spi_master m (.i_clk(i_clk), .o_sck(i_sck), .o_cs_n(i_cs_n),
    .o_mosi(i_mosi), .i_miso(o_miso), .i_miso_oe(o_miso_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_frame(logic [7:0] c, logic u, t);
    return {c, u, t,
      ~^c, ~^c[7:4], ~^c[3:0], ~^c[5:2], 2'b01};
  endfunction
  task automatic close_out();
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge i_clk);
    i_in_valid = 1'b1;
    i_in_data = d;
    for (int k = 0; k < 50 && o_in_ready !== 1'b1; k++) @(negedge i_clk);
    chk(o_in_ready, 1'b1);
    @(negedge i_clk);
    i_in_valid = 1'b0;
  endtask
  task automatic frame(input logic s, input logic [7:0] c, input logic u, t);
    logic [23:0] rx, e;
    seed = lfsr(seed);
    i_frame_length_select = s;
    m.xfer(s ? 16 : 24, seed[7:0], rx);
    e = s ? {8'h00, c, seed[7:0]} : {exp_frame(c, u, t), seed[7:0]};
    chk(rx, e);
  endtask
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    logic [7:0] w;
    logic [23:0] rx;
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    chk({o_in_ready, o_undervoltage_alarm_n, o_overtemp_alarm_n,
      o_miso_oe, o_channel_state}, 12'hE00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[15:8];
      push(w);
      repeat (3) @(negedge i_clk);
      chk(o_channel_state, w);
      frame(i[0], w, 1'b1, 1'b1);
    end
    // words offered mid frame wait in the buffer, which then reads full
    fork
      frame(1'b0, w, 1'b1, 1'b1);
      begin
        repeat (8) @(negedge i_clk);
        push(8'h3C);
        push(8'hC3);
        @(negedge i_clk);
        chk(o_in_ready, 1'b0);
        chk(o_channel_state, w);
      end
    join
    repeat (4) @(negedge i_clk);
    chk(o_channel_state, 8'hC3);
    w = 8'hC3;
    i_uv_below_on = 1'b1;
    i_uv_above_off = 1'b0;
    repeat (10) @(negedge i_clk);
    i_uv_below_on = 1'b0;
    repeat (10) @(negedge i_clk);
    chk(o_undervoltage_alarm_n, 1'b1);
    i_uv_below_on = 1'b1;
    i_ot_above_on = 1'b1;
    i_ot_below_off = 1'b0;
    repeat (30) @(negedge i_clk);
    i_ot_above_on = 1'b0;
    repeat (10) @(negedge i_clk);
    chk({o_undervoltage_alarm_n, o_overtemp_alarm_n},
      2'b00);
    frame(1'b0, w, 1'b0, 1'b0);
    i_uv_below_on = 1'b0;
    i_uv_above_off = 1'b1;
    i_ot_below_off = 1'b1;
    repeat (30) @(negedge i_clk);
    chk({o_undervoltage_alarm_n, o_overtemp_alarm_n},
      2'b11);
    i_por_n = 1'b0;
    repeat (5) @(negedge i_clk);
    m.xfer(24, 8'hFF, rx);
    chk(rx, 24'h000000);
    close_out();
  end
endmodule
bind isf_input_state_spi_frame isf_frame_monitor
  #(.UV_FILTER_CYC(UV_FILTER_CYC)) mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_por_n(i_por_n),
  .i_uv_below_on(i_uv_below_on), .i_ot_above_on(i_ot_above_on),
  .i_ot_below_off(i_ot_below_off), .o_miso(o_miso),
  .o_miso_oe(o_miso_oe), .o_in_ready(o_in_ready),
  .o_undervoltage_alarm_n(o_undervoltage_alarm_n),
  .o_overtemp_alarm_n(o_overtemp_alarm_n),
  .o_channel_state(o_channel_state));

// file: src/isf_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, producer and consumer on i_clk
// Notes: full and empty come straight from the entry count
module isf_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] data;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } isf_b2_type;

  isf_b2_type st_r;
  isf_b2_type st_nxt;
  logic push;
  logic pop;

  assign o_ready = (st_r.count != 2'h2);
  assign o_valid = (st_r.count != 2'h0);
  assign o_data = st_r.data[st_r.rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.data[st_r.wr_ptr] = i_data;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 2'h1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: src/isf_input_state_spi_frame.sv
// Purpose: slave serializer of eight filtered input states with alarms
// Assumes: serial link pins sampled by i_clk, link clock far below i_clk
// Notes: link runs in mode 0; link edges are found by oversampling
module isf_input_state_spi_frame #(
  parameter int UV_FILTER_CYC = isf_pkg::UV_FILTER_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // filtered channel states, bit 0 is channel 1
  input wire logic i_in_valid,
  input wire logic [7:0] i_in_data,
  output logic o_in_ready,
  // serial link pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // configuration and supply pins
  input wire logic i_frame_length_select,
  input wire logic i_por_n,
  // analog comparator outputs
  input wire logic i_uv_below_on,
  input wire logic i_uv_above_off,
  input wire logic i_ot_above_on,
  input wire logic i_ot_below_off,
  // status
  output logic o_undervoltage_alarm_n,
  output logic o_overtemp_alarm_n,
  output logic [7:0] o_channel_state
);
  localparam int UVW = $clog2(UV_FILTER_CYC + 1);

  typedef struct packed {
    isf_pkg::isf_pins_type s1;
    isf_pkg::isf_pins_type s2;
    logic sck_d;
    logic cs_n_d;
    logic active;
    logic short_mode;
    logic mosi_cap;
    logic [15:0] shreg;
    logic [7:0] chan;
    logic undervoltage_alarm_n;
    logic [UVW-1:0] uv_cnt;
    logic overtemp_alarm_n;
    isf_pkg::isf_link_out_type lo;
  } isf_state_type;

  isf_state_type st_r;
  isf_state_type st_nxt;
  isf_pkg::isf_pins_type pins;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_take;

  assign pins = '{sck: i_sck, cs_n: i_cs_n, mosi: i_mosi,
                  frame_length_select: i_frame_length_select,
                  por_n: i_por_n, uv_below_on: i_uv_below_on,
                  uv_above_off: i_uv_above_off,
                  ot_above_on: i_ot_above_on,
                  ot_below_off: i_ot_below_off};

  // states only move into the snapshot between frames, so a long frame
  // stalls the producer once both entries are taken
  assign buf_take = st_r.s2.cs_n;

  isf_buf2 #(
    .WIDTH(isf_pkg::NUM_CH)
  ) u_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_in_valid),
    .i_data(i_in_data),
    .o_ready(o_in_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(buf_take)
  );

  function automatic logic [15:0] build_frame(input logic [7:0] ch,
                                              input logic uv_n,
                                              input logic ot_n);
    logic [15:0] f;
    f = isf_pkg::SHIFT_RESET;
    f[15:8] = ch;
    f[isf_pkg::BIT_UV_N] = uv_n;
    f[isf_pkg::BIT_OT_N] = ot_n;
    f[isf_pkg::BIT_PAR_FULL] = ~(^ch);
    f[isf_pkg::BIT_PAR_UPPER] = ~(^ch[7:4]);
    f[isf_pkg::BIT_PAR_LOWER] = ~(^ch[3:0]);
    f[isf_pkg::BIT_PAR_MIDDLE] = ~(^ch[5:2]);
    f[isf_pkg::BIT_STOP_LOW] = isf_pkg::STOP_LOW_VAL;
    f[isf_pkg::BIT_STOP_HIGH] = isf_pkg::STOP_HIGH_VAL;
    return f;
  endfunction

  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic [15:0] fr;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    fr = isf_pkg::SHIFT_RESET;
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.sck_d = st_r.s2.sck;
    st_nxt.cs_n_d = st_r.s2.cs_n;
    sck_rise = st_r.s2.sck & ~st_r.sck_d;
    sck_fall = ~st_r.s2.sck & st_r.sck_d;
    cs_fall = ~st_r.s2.cs_n & st_r.cs_n_d;
    cs_rise = st_r.s2.cs_n & ~st_r.cs_n_d;

    if (buf_valid && buf_take) begin
      st_nxt.chan = buf_data;
    end

    // undervoltage: set only after the low level holds for the filter time
    if (st_r.undervoltage_alarm_n) begin
      if (st_r.s2.uv_below_on) begin
        if (st_r.uv_cnt == UVW'(UV_FILTER_CYC - 1)) begin
          st_nxt.undervoltage_alarm_n = 1'b0;
          st_nxt.uv_cnt = '0;
        end else begin
          st_nxt.uv_cnt = st_r.uv_cnt + UVW'(1);
        end
      end else begin
        st_nxt.uv_cnt = '0;
      end
    end else begin
      if (st_r.s2.uv_above_off) begin
        if (st_r.uv_cnt == UVW'(UV_FILTER_CYC - 1)) begin
          st_nxt.undervoltage_alarm_n = 1'b1;
          st_nxt.uv_cnt = '0;
        end else begin
          st_nxt.uv_cnt = st_r.uv_cnt + UVW'(1);
        end
      end else begin
        st_nxt.uv_cnt = '0;
      end
    end

    if (st_r.s2.ot_above_on) begin
      st_nxt.overtemp_alarm_n = 1'b0;
    end else if (st_r.s2.ot_below_off) begin
      st_nxt.overtemp_alarm_n = 1'b1;
    end

    fr = build_frame(st_r.chan, st_r.undervoltage_alarm_n,
                     st_r.overtemp_alarm_n);

    if (cs_rise || st_r.s2.cs_n) begin
      // clock and data ignored while deselected
      st_nxt.active = 1'b0;
    end else if (cs_fall) begin
      st_nxt.active = 1'b1;
      st_nxt.short_mode = st_r.s2.frame_length_select;
      st_nxt.shreg = fr;
    end else if (st_r.active) begin
      if (sck_rise) begin
        st_nxt.mosi_cap = st_r.s2.mosi;
      end
      if (sck_fall) begin
        if (st_r.short_mode) begin
          st_nxt.shreg[15:8] = {st_r.shreg[14:8], st_r.mosi_cap};
        end else begin
          st_nxt.shreg = {st_r.shreg[14:0], st_r.mosi_cap};
        end
      end
    end

    // output is registered from the next state, in step with the register; power loss forces low
    st_nxt.lo.miso_oe = st_nxt.active;
    st_nxt.lo.miso = st_nxt.active & st_r.s2.por_n &
                     st_nxt.shreg[15];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.s1.cs_n <= 1'b1;
      st_r.s2.cs_n <= 1'b1;
      st_r.cs_n_d <= 1'b1;
      st_r.chan <= isf_pkg::CH_RESET;
      st_r.shreg <= isf_pkg::SHIFT_RESET;
      st_r.undervoltage_alarm_n <= isf_pkg::ALARM_RESET_N;
      st_r.overtemp_alarm_n <= isf_pkg::ALARM_RESET_N;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_miso = st_r.lo.miso;
  assign o_miso_oe = st_r.lo.miso_oe;
  assign o_undervoltage_alarm_n = st_r.undervoltage_alarm_n;
  assign o_overtemp_alarm_n = st_r.overtemp_alarm_n;
  assign o_channel_state = st_r.chan;
endmodule

// file: src/isf_pkg.sv
// Purpose: shared constants and carriers for the input state frame block
// Assumes: system clock of 50 MHz
// Notes: frame bit positions follow the long-frame layout
package isf_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int NUM_CH = 8;
  localparam int FRAME_BITS = 16;
  localparam int SHORT_BITS = 8;
  // undervoltage dropout filter, figure in microseconds
  localparam int UV_FILTER_US = 1000;
  localparam int UV_FILTER_CYC = (CLK_HZ / 1000000) * UV_FILTER_US;
  // control byte field positions
  localparam int BIT_UV_N = 7;
  localparam int BIT_OT_N = 6;
  localparam int BIT_PAR_FULL = 5;
  localparam int BIT_PAR_UPPER = 4;
  localparam int BIT_PAR_LOWER = 3;
  localparam int BIT_PAR_MIDDLE = 2;
  localparam int BIT_STOP_LOW = 1;
  localparam int BIT_STOP_HIGH = 0;
  localparam logic STOP_LOW_VAL = 1'h0;
  localparam logic STOP_HIGH_VAL = 1'h1;
  // reset values
  localparam logic [7:0] CH_RESET = 8'h00;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic ALARM_RESET_N = 1'h1;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
    logic frame_length_select;
    logic por_n;
    logic uv_below_on;
    logic uv_above_off;
    logic ot_above_on;
    logic ot_below_off;
  } isf_pins_type;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } isf_link_out_type;

  typedef struct packed {
    logic [1:0][7:0] data;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } isf_buf_type;
endpackage
